// *** include/flash_prog_pkg.sv ***
// Constants, codes and types for the parallel flash programming port.
// Assumes one 125 MHz system clock; the flash array controller sits outside.
`default_nettype none
package flash_prog_pkg;

   localparam logic [3:0]  COMMAND_SELECT_CODE  = 4'h0;
   localparam logic [3:0]  ADDRESS_LOW_SELECT   = 4'h1;
   localparam logic [3:0]  ADDRESS_HIGH_SELECT  = 4'h2;
   localparam logic [3:0]  DATA_SELECT          = 4'h5;

   localparam logic [15:0] READ_CMD             = 16'h0011;
   localparam logic [15:0] PAGE_WRITE_CMD       = 16'h0012;
   localparam logic [15:0] PAGE_WRITE_LOCK_CMD  = 16'h0022;
   localparam logic [15:0] ERASE_THEN_WRITE_CMD = 16'h0032;
   localparam logic [15:0] ERASE_WRITE_LOCK_CMD = 16'h0042;
   localparam logic [15:0] FULL_ERASE_CMD       = 16'h0013;
   localparam logic [15:0] SET_LOCK_CMD         = 16'h0014;
   localparam logic [15:0] CLEAR_LOCK_CMD       = 16'h0024;
   localparam logic [15:0] GET_LOCK_CMD         = 16'h0015;
   localparam logic [15:0] SET_GP_BIT_CMD       = 16'h0034;
   localparam logic [15:0] CLEAR_GP_BIT_CMD     = 16'h0044;
   localparam logic [15:0] GET_GP_BIT_CMD       = 16'h0025;
   localparam logic [15:0] SET_SECURE_CMD       = 16'h0054;
   localparam logic [15:0] GET_SECURE_CMD       = 16'h0035;
   localparam logic [15:0] MEMORY_WRITE_CMD     = 16'h001F;
   localparam logic [15:0] GET_VERSION_CMD      = 16'h001E;

   localparam logic [1:0]  FOP_ERASE            = 2'h0;
   localparam logic [1:0]  FOP_PROGRAM          = 2'h1;
   localparam logic [1:0]  FOP_LOCK             = 2'h2;

   localparam int          SYS_CLK_HZ           = 125000000;
   localparam int          EXT_CLK_MIN_HZ       = 32000;
   // Longest period of an acceptable external clock, rounded down
   localparam int          EXT_PERIOD_CYCLES    = SYS_CLK_HZ / EXT_CLK_MIN_HZ;
   localparam logic [11:0] EXT_PERIOD_CNT       = 12'(EXT_PERIOD_CYCLES);

   localparam logic [15:0] WORD_RESET           = 16'h0000;

   typedef enum logic [4:0] {
      K_NONE, K_READ, K_PAGE_WRITE, K_PAGE_WRITE_LOCK, K_ERASE_WRITE, K_ERASE_WRITE_LOCK,
      K_FULL_ERASE, K_SET_LOCK, K_CLEAR_LOCK, K_GET_LOCK, K_SET_GP, K_CLEAR_GP, K_GET_GP,
      K_SET_SECURE, K_GET_SECURE, K_MEM_WRITE, K_GET_VERSION
   } cmd_kind_e;

   typedef enum logic [3:0] {
      S_IDLE, S_EXEC, S_ERASE, S_PROG, S_LOCK, S_OE_LOW, S_FETCH, S_DRIVE, S_OE_HIGH,
      S_WAIT_HIGH
   } port_state_e;

endpackage
`default_nettype wire

// *** hdl/page_load_buffer.sv ***
// One-page load buffer: single write port, registered read port.
// Written by the programming port, read by the flash array controller.
`timescale 1ns/10ps
`default_nettype none
module page_load_buffer #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 256,
   parameter int AW    = $clog2(DEPTH)
) (
   input  wire logic             sys_clk,
   input  wire logic             wrEn,
   input  wire logic [AW-1:0]    wrAddr,
   input  wire logic [WIDTH-1:0] wrData,
   input  wire logic [AW-1:0]    rdAddr,
   output var  logic [WIDTH-1:0] rdData
);
   // No reset: contents are don't-care until written
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge sys_clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
   end
endmodule
`default_nettype wire

// *** hdl/flash_parallel_program_port.sv ***
// Parallel flash programming port: handshake engine, command decode,
// address counter and page load buffer flushing.
// Assumes pins are asynchronous to sys_clk and the flash array answers reads one cycle later.
`timescale 1ns/10ps
`default_nettype none
module flash_parallel_program_port
   import flash_prog_pkg::*;
#(
   parameter int PAGE_WORDS = 256,
   parameter int PW         = $clog2(PAGE_WORDS)
) (
   input  wire logic          sys_clk,
   input  wire logic          rst,
   input  wire logic          cmd_strobe_n,
   input  wire logic [3:0]    modeSel,
   input  wire logic [15:0]   dataIn,
   output logic      [15:0]   dataOut,
   output logic               dataOe,
   output logic               ready,
   input  wire logic          read_output_enable_n,
   output logic               read_data_valid_n,
   input  wire logic          ext_clock_in,
   output logic               useExtClock,
   output var cmd_kind_e      cmdKind,
   output logic      [31:0]   flashRdAddr,
   input  wire logic [15:0]   flashRdData,
   output logic               flashOpValid,
   output logic      [1:0]    flashOp,
   output logic      [31:0]   flashOpPage,
   input  wire logic          flashOpDone,
   input  wire logic [PW-1:0] pbufRdAddr,
   output logic      [15:0]   pbufRdData
);

   typedef struct packed {
      port_state_e st;
      logic        strobeMeta;
      logic        strobeN;
      logic        oeMeta;
      logic        oeN;
      logic [3:0]  modeMeta;
      logic [3:0]  modeSync;
      logic [15:0] dataMeta;
      logic [15:0] dataSync;
      logic        extMeta;
      logic        extSync;
      logic        extPrev;
      logic        extSeen;
      logic        extFast;
      logic [11:0] extGap;
      logic        decided;
      logic        useExt;
      logic [3:0]  mode;
      logic [15:0] word;
      cmd_kind_e   kind;
      cmd_kind_e   bufKind;
      logic [15:0] addrLo;
      logic [15:0] addrHi;
      logic        dirty;
      logic [31:0] bufPage;
      logic        ready;
      logic        validN;
      logic        dataOe;
      logic [15:0] dataOut;
      logic [1:0]  op;
   } port_s;

   port_s q;
   port_s d;

   logic [31:0]   curAddr;
   logic [31:0]   nextAddr;
   logic [31:0]   curPage;
   logic          bufWe;
   logic          isWriteKind;
   logic          bufErase;
   logic          bufLock;

   function automatic cmd_kind_e decodeCmd(input logic [15:0] w);
      cmd_kind_e k;
      k = K_NONE;
      case (w)
         READ_CMD:             k = K_READ;
         PAGE_WRITE_CMD:       k = K_PAGE_WRITE;
         PAGE_WRITE_LOCK_CMD:  k = K_PAGE_WRITE_LOCK;
         ERASE_THEN_WRITE_CMD: k = K_ERASE_WRITE;
         ERASE_WRITE_LOCK_CMD: k = K_ERASE_WRITE_LOCK;
         FULL_ERASE_CMD:       k = K_FULL_ERASE;
         SET_LOCK_CMD:         k = K_SET_LOCK;
         CLEAR_LOCK_CMD:       k = K_CLEAR_LOCK;
         GET_LOCK_CMD:         k = K_GET_LOCK;
         SET_GP_BIT_CMD:       k = K_SET_GP;
         CLEAR_GP_BIT_CMD:     k = K_CLEAR_GP;
         GET_GP_BIT_CMD:       k = K_GET_GP;
         SET_SECURE_CMD:       k = K_SET_SECURE;
         GET_SECURE_CMD:       k = K_GET_SECURE;
         MEMORY_WRITE_CMD:     k = K_MEM_WRITE;
         GET_VERSION_CMD:      k = K_GET_VERSION;
         default:              k = K_NONE;
      endcase
      return k;
   endfunction

   assign curAddr     = {q.addrHi, q.addrLo};
   assign nextAddr    = curAddr + 32'h0000_0001;
   assign curPage     = curAddr >> PW;
   assign isWriteKind = (q.kind == K_PAGE_WRITE) || (q.kind == K_PAGE_WRITE_LOCK) ||
                        (q.kind == K_ERASE_WRITE) || (q.kind == K_ERASE_WRITE_LOCK);
   assign bufErase    = (q.bufKind == K_ERASE_WRITE) || (q.bufKind == K_ERASE_WRITE_LOCK);
   assign bufLock     = (q.bufKind == K_PAGE_WRITE_LOCK) || (q.bufKind == K_ERASE_WRITE_LOCK);

   always_comb begin
      d     = q;
      bufWe = 1'b0;
      // Two-stage synchronisers on every pin
      d.strobeMeta = cmd_strobe_n;
      d.strobeN    = q.strobeMeta;
      d.oeMeta     = read_output_enable_n;
      d.oeN        = q.oeMeta;
      d.modeMeta   = modeSel;
      d.modeSync   = q.modeMeta;
      d.dataMeta   = dataIn;
      d.dataSync   = q.dataMeta;
      d.extMeta    = ext_clock_in;
      d.extSync    = q.extMeta;
      d.extPrev    = q.extSync;
      // External clock qualification, frozen once the first handshake starts
      if (!q.decided) begin
         if (q.extSync && !q.extPrev) begin
            if (q.extSeen && (q.extGap < EXT_PERIOD_CNT)) begin
               d.extFast = 1'b1;
            end
            d.extSeen = 1'b1;
            d.extGap  = 12'h000;
         end else if (q.extGap < EXT_PERIOD_CNT) begin
            d.extGap = q.extGap + 12'h001;
         end
      end

      case (q.st)
         S_IDLE: begin
            if (!q.strobeN) begin
               d.mode  = q.modeSync;
               d.word  = q.dataSync;
               d.ready = 1'b0;
               d.st    = S_EXEC;
               if (!q.decided) begin
                  d.decided = 1'b1;
                  d.useExt  = q.extFast;
               end
            end
         end
         S_EXEC: begin
            d.st = S_WAIT_HIGH;
            case (q.mode)
               COMMAND_SELECT_CODE: begin
                  // Finish any pending page before the new command takes over
                  if (q.dirty) begin
                     d.op = bufErase ? FOP_ERASE : FOP_PROGRAM;
                     d.st = bufErase ? S_ERASE : S_PROG;
                  end else begin
                     d.kind = decodeCmd(q.word);
                  end
               end
               ADDRESS_LOW_SELECT: begin
                  d.addrLo = q.word;
               end
               ADDRESS_HIGH_SELECT: begin
                  d.addrHi = q.word;
               end
               DATA_SELECT: begin
                  if (q.kind == K_READ) begin
                     d.st = S_OE_LOW;
                  end else if (isWriteKind) begin
                     if (q.dirty && (curPage != q.bufPage)) begin
                        d.op = bufErase ? FOP_ERASE : FOP_PROGRAM;
                        d.st = bufErase ? S_ERASE : S_PROG;
                     end else begin
                        bufWe     = 1'b1;
                        d.dirty   = 1'b1;
                        d.bufPage = curPage;
                        d.bufKind = q.kind;
                        d.addrLo  = nextAddr[15:0];
                        d.addrHi  = nextAddr[31:16];
                     end
                  end
               end
               default: begin
                  d.st = S_WAIT_HIGH;
               end
            endcase
         end
         S_ERASE: begin
            if (flashOpDone) begin
               d.op = FOP_PROGRAM;
               d.st = S_PROG;
            end
         end
         S_PROG: begin
            if (flashOpDone) begin
               if (bufLock) begin
                  d.op = FOP_LOCK;
                  d.st = S_LOCK;
               end else begin
                  d.dirty = 1'b0;
                  d.st    = S_EXEC; // Replay the word that caused the flush
               end
            end
         end
         S_LOCK: begin
            if (flashOpDone) begin
               d.dirty = 1'b0;
               d.st    = S_EXEC;
            end
         end
         S_OE_LOW: begin
            // Drive only after the programmer has tristated its side
            if (!q.oeN) begin
               d.st = S_FETCH;
            end
         end
         S_FETCH: begin
            d.st = S_DRIVE;
         end
         S_DRIVE: begin
            d.dataOut = flashRdData;
            d.dataOe  = 1'b1;
            d.validN  = 1'b0;
            d.addrLo  = nextAddr[15:0];
            d.addrHi  = nextAddr[31:16];
            d.st      = S_OE_HIGH;
         end
         S_OE_HIGH: begin
            if (q.oeN) begin
               d.dataOe = 1'b0;
               d.validN = 1'b1;
               d.st     = S_WAIT_HIGH;
            end
         end
         S_WAIT_HIGH: begin
            if (q.strobeN) begin
               d.ready = 1'b1;
               d.st    = S_IDLE;
            end
         end
         default: begin
            d.st = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         q            <= '0;
         q.st         <= S_IDLE;
         q.strobeMeta <= 1'b1;
         q.strobeN    <= 1'b1;
         q.oeMeta     <= 1'b1;
         q.oeN        <= 1'b1;
         q.word       <= WORD_RESET;
         q.kind       <= K_NONE;
         q.bufKind    <= K_NONE;
         q.ready      <= 1'b1;
         q.validN     <= 1'b1;
         q.op         <= FOP_PROGRAM;
      end else begin
         q <= d;
      end
   end

   page_load_buffer #(
      .WIDTH (16),
      .DEPTH (PAGE_WORDS)
   ) page_load_buffer_i (
      .sys_clk (sys_clk),
      .wrEn    (bufWe),
      .wrAddr  (curAddr[PW-1:0]),
      .wrData  (q.word),
      .rdAddr  (pbufRdAddr),
      .rdData  (pbufRdData)
   );

   assign dataOut           = q.dataOut;
   assign dataOe            = q.dataOe;
   assign ready             = q.ready;
   assign read_data_valid_n = q.validN;
   assign useExtClock       = q.useExt;
   assign cmdKind           = q.kind;
   assign flashRdAddr       = curAddr;
   // Level request held until the done pulse, so the controller may stall freely
   assign flashOpValid      = (q.st == S_ERASE) || (q.st == S_PROG) || (q.st == S_LOCK);
   assign flashOp           = q.op;
   assign flashOpPage       = q.bufPage;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence oeTaken;
      (q.st == S_OE_LOW) && !q.oeN;
   endsequence
   sequence wordDriven;
      !q.validN && q.dataOe;
   endsequence
   sequence progFinished;
      (q.st == S_PROG) && flashOpDone;
   endsequence

   AST_CMD_STORE: assert property ((q.st == S_EXEC) && (q.mode == COMMAND_SELECT_CODE)
      && !q.dirty |=> q.kind == decodeCmd($past(q.word)))
      else $error("command word not stored");
   AST_ADDR_LOW: assert property ((q.st == S_EXEC) && (q.mode == ADDRESS_LOW_SELECT)
      |=> q.addrLo == $past(q.word))
      else $error("low address not latched");
   AST_READY_DROP: assert property ((q.st == S_IDLE) && !q.strobeN
      |=> !q.ready && (q.st == S_EXEC))
      else $error("ready not cleared after strobe");
   AST_READY_RISE: assert property ($rose(q.ready) |-> $past(q.strobeN)
      && ($past(q.st) == S_WAIT_HIGH))
      else $error("ready rose with strobe low");
   AST_READ_DRIVE: assert property (oeTaken |=> ##2 wordDriven)
      else $error("word not driven after output enable");
   AST_VALID_OE: assert property (!q.validN |-> q.dataOe)
      else $error("valid low without driving the bus");
   AST_RELEASE: assert property ((q.st == S_OE_HIGH) && q.oeN
      |=> q.validN && !q.dataOe)
      else $error("bus not released after output enable rose");
   AST_WRITE_INC: assert property (bufWe |=> curAddr == $past(curAddr) + 32'h0000_0001)
      else $error("address not incremented after write");
   AST_FLUSH_ON_CMD: assert property ((q.st == S_EXEC) && (q.mode == COMMAND_SELECT_CODE)
      && q.dirty |=> flashOpValid && (q.kind == $past(q.kind)))
      else $error("pending page not flushed on new command");
   AST_LOCK_AFTER: assert property (progFinished and bufLock |=> (q.st == S_LOCK)
      && (q.op == FOP_LOCK))
      else $error("lock not issued after write");
   AST_ERASE_FIRST: assert property ((q.st == S_ERASE) && flashOpDone
      |=> (q.st == S_PROG) && (q.op == FOP_PROGRAM))
      else $error("program not following erase");
   AST_EXT_FROZEN: assert property (q.decided |=> $stable(q.useExt))
      else $error("clock choice changed after first handshake");

endmodule
`default_nettype wire

// *** test/flash_model.sv ***
// Behavioural flash array controller facing the programming port.
// Assumes the port holds flashOpValid until flashOpDone and reads the buffer one cycle late.
`timescale 1ns/10ps
`default_nettype none
module flash_model
   import flash_prog_pkg::*;
#(
   parameter int PAGE_WORDS = 4,
   parameter int PW         = 2
) (
   input  wire logic          sys_clk,
   input  wire logic          rst,
   input  wire logic [31:0]   flashRdAddr,
   output logic      [15:0]   flashRdData,
   input  wire logic          flashOpValid,
   input  wire logic [1:0]    flashOp,
   input  wire logic [31:0]   flashOpPage,
   output logic               flashOpDone,
   output logic      [PW-1:0] pbufRdAddr,
   input  wire logic [15:0]   pbufRdData
);
   logic [15:0] mem [0:63];
   logic [5:0]  opLog [$];
   int          opDelay = 2;
   logic [1:0]  op;
   logic [3:0]  pg;

   always @(posedge sys_clk) begin
      flashRdData <= mem[flashRdAddr[5:0]];
   end

   // Small array; only the low address bits are decoded
   initial begin
      for (int i = 0; i < 64; i++) begin
         mem[i] = 16'hA500 ^ 16'(i);
      end
      flashOpDone = 1'b0;
      pbufRdAddr  = '0;
      forever begin
         @(posedge sys_clk);
         if (flashOpValid === 1'b1 && rst === 1'b0) begin
            op = flashOp;
            pg = flashOpPage[3:0];
            opLog.push_back({op, pg});
            for (int i = 0; i < PAGE_WORDS; i++) begin
               if (op == FOP_ERASE) begin
                  mem[pg * PAGE_WORDS + i] = 16'hFFFF;
               end
               if (op == FOP_PROGRAM) begin
                  pbufRdAddr <= PW'(i);
                  repeat (2) @(posedge sys_clk);
                  mem[pg * PAGE_WORDS + i] = pbufRdData;
               end
            end
            // Variable latency so the port must wait on flashOpDone
            repeat (opDelay) @(posedge sys_clk);
            flashOpDone <= 1'b1;
            @(posedge sys_clk);
            flashOpDone <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// *** test/flash_parallel_program_port_tb.sv ***
// Self-checking bench for the parallel flash programming port.
// Bench plays the gang programmer; flash_model plays the flash array controller.
`timescale 1ns/10ps
`default_nettype none
module flash_parallel_program_port_tb
   import flash_prog_pkg::*;
;
   localparam int PAGE_WORDS = 4;
   localparam int PW         = 2;

   logic          sys_clk     = 1'b0;
   logic          rst         = 1'b1;
   logic          cmdStrobeN  = 1'b1;
   logic [3:0]    modeSel     = 4'hF;
   logic [15:0]   tbData      = 16'hFFFF;
   logic          tbOe        = 1'b0;
   logic          readOeN     = 1'b1;
   logic          extClk      = 1'b0;
   logic          extRun      = 1'b1;
   wire  [15:0]   busWire;
   logic [15:0]   dataOut;
   logic          dataOe;
   logic          ready;
   logic          readValidN;
   logic          useExtClock;
   cmd_kind_e     cmdKind;
   logic [31:0]   flashRdAddr;
   logic [15:0]   flashRdData;
   logic          flashOpValid;
   logic [1:0]    flashOp;
   logic [31:0]   flashOpPage;
   logic          flashOpDone;
   logic [PW-1:0] pbufRdAddr;
   logic [15:0]   pbufRdData;
   int            fails       = 0;
   int            checks_done = 0;

   always #4 sys_clk = ~sys_clk;
   // Stopping it leaves the pin low, as when it is tied to ground
   always #400 extClk = extRun & ~extClk;
   // Pulled-up bus: released by both sides reads all ones
   assign busWire = dataOe ? dataOut : (tbOe ? tbData : 16'hFFFF);

   flash_parallel_program_port #(.PAGE_WORDS(PAGE_WORDS), .PW(PW)) flash_parallel_program_port_i (
      .sys_clk(sys_clk), .rst(rst), .cmd_strobe_n(cmdStrobeN), .modeSel(modeSel),
      .dataIn(busWire), .dataOut(dataOut), .dataOe(dataOe), .ready(ready),
      .read_output_enable_n(readOeN), .read_data_valid_n(readValidN),
      .ext_clock_in(extClk), .useExtClock(useExtClock), .cmdKind(cmdKind),
      .flashRdAddr(flashRdAddr), .flashRdData(flashRdData), .flashOpValid(flashOpValid),
      .flashOp(flashOp), .flashOpPage(flashOpPage), .flashOpDone(flashOpDone),
      .pbufRdAddr(pbufRdAddr), .pbufRdData(pbufRdData)
   );

   flash_model #(.PAGE_WORDS(PAGE_WORDS), .PW(PW)) flash_model_i (
      .sys_clk(sys_clk), .rst(rst), .flashRdAddr(flashRdAddr), .flashRdData(flashRdData),
      .flashOpValid(flashOpValid), .flashOp(flashOp), .flashOpPage(flashOpPage),
      .flashOpDone(flashOpDone), .pbufRdAddr(pbufRdAddr), .pbufRdData(pbufRdData)
   );

   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Bounded wait on ready (sel 0) or data valid (sel 1)
   task automatic wait_lvl(input int sel, input logic lvl);
      int n;
      n = 0;
      while (((sel == 0) ? ready : readValidN) !== lvl && n < 5000) begin
         @(posedge sys_clk);
         n++;
      end
      if (n >= 5000) begin
         fails++;
         $display("mismatch handshake level expected %b seen timeout", lvl);
      end
   endtask

   task automatic wr_hs(input logic [3:0] mode, input logic [15:0] data);
      @(posedge sys_clk);
      modeSel <= mode;
      tbData  <= data;
      tbOe    <= 1'b1;
      // Pins cross two-stage synchronisers, so settle first
      repeat (3) @(posedge sys_clk);
      cmdStrobeN <= 1'b0;
      @(posedge sys_clk);
      wait_lvl(0, 1'b0);
      modeSel <= 4'hF;
      tbOe    <= 1'b0;
      @(posedge sys_clk);
      cmdStrobeN <= 1'b1;
      wait_lvl(0, 1'b1);
   endtask

   task automatic rd_hs(input logic [15:0] exp, input logic [31:0] nextAddr);
      @(posedge sys_clk);
      modeSel <= DATA_SELECT;
      repeat (3) @(posedge sys_clk);
      cmdStrobeN <= 1'b0;
      @(posedge sys_clk);
      wait_lvl(0, 1'b0);
      modeSel <= 4'hF;
      tbOe    <= 1'b0;
      @(posedge sys_clk);
      readOeN <= 1'b0;
      wait_lvl(1, 1'b0);
      chk("read word", {16'h0, exp}, {16'h0, busWire});
      chk("read drive", 32'd1, {31'h0, dataOe});
      chk("read address", nextAddr, flashRdAddr);
      readOeN <= 1'b1;
      wait_lvl(1, 1'b1);
      chk("read release", 32'd0, {31'h0, dataOe});
      @(posedge sys_clk);
      cmdStrobeN <= 1'b1;
      wait_lvl(0, 1'b1);
   endtask

   task automatic t_reset;
      chk("ready", 32'd1, {31'h0, ready});
      chk("valid", 32'd1, {31'h0, readValidN});
      chk("bus drive", 32'd0, {31'h0, dataOe});
      chk("ext clock", 32'd0, {31'h0, useExtClock});
      chk("command", 32'(K_NONE), 32'(cmdKind));
   endtask

   task automatic t_decode;
      logic [15:0] codes [16];
      codes = '{READ_CMD, PAGE_WRITE_CMD, PAGE_WRITE_LOCK_CMD, ERASE_THEN_WRITE_CMD,
                ERASE_WRITE_LOCK_CMD, FULL_ERASE_CMD, SET_LOCK_CMD, CLEAR_LOCK_CMD,
                GET_LOCK_CMD, SET_GP_BIT_CMD, CLEAR_GP_BIT_CMD, GET_GP_BIT_CMD,
                SET_SECURE_CMD, GET_SECURE_CMD, MEMORY_WRITE_CMD, GET_VERSION_CMD};
      for (int i = 0; i < 16; i++) begin
         wr_hs(COMMAND_SELECT_CODE, codes[i]);
         chk("decoded kind", 32'(i + 1), 32'(cmdKind));
         if (i == 0) begin
            chk("ext clock", 32'd1, {31'h0, useExtClock});
         end
      end
      wr_hs(4'h3, PAGE_WRITE_CMD);
      chk("unmapped mode", 32'(K_GET_VERSION), 32'(cmdKind));
   endtask

   task automatic t_write_read;
      flash_model_i.opLog.delete();
      wr_hs(COMMAND_SELECT_CODE, PAGE_WRITE_CMD);
      wr_hs(ADDRESS_LOW_SELECT, 16'h0004);
      wr_hs(ADDRESS_HIGH_SELECT, 16'h0001);
      chk("address join", 32'h0001_0004, flashRdAddr);
      wr_hs(ADDRESS_HIGH_SELECT, 16'h0000);
      for (int i = 0; i < 3; i++) begin
         wr_hs(DATA_SELECT, 16'hC0DE + 16'(i));
      end
      chk("write address", 32'd7, flashRdAddr);
      chk("early flush", 32'd0, flash_model_i.opLog.size());
      wr_hs(ADDRESS_LOW_SELECT, 16'h0008);
      wr_hs(DATA_SELECT, 16'hBEEF);
      chk("page change flush", {26'h0, FOP_PROGRAM, 4'h1}, {26'h0, flash_model_i.opLog[0]});
      wr_hs(COMMAND_SELECT_CODE, READ_CMD);
      chk("command flush", {26'h0, FOP_PROGRAM, 4'h2}, {26'h0, flash_model_i.opLog[1]});
      chk("replayed command", 32'(K_READ), 32'(cmdKind));
      wr_hs(ADDRESS_LOW_SELECT, 16'h0004);
      rd_hs(16'hC0DE, 32'd5);
      rd_hs(16'hC0DF, 32'd6);
      rd_hs(16'hC0E0, 32'd7);
      wr_hs(ADDRESS_LOW_SELECT, 16'h0008);
      rd_hs(16'hBEEF, 32'd9);
   endtask

   task automatic t_variant(input logic [15:0] cmd, input logic er, input logic lk,
                            input logic [3:0] pg);
      logic [5:0] exp [$];
      flash_model_i.opLog.delete();
      wr_hs(COMMAND_SELECT_CODE, cmd);
      wr_hs(ADDRESS_LOW_SELECT, {10'h0, pg, 2'h0});
      wr_hs(DATA_SELECT, 16'h5A00 + 16'(pg));
      wr_hs(COMMAND_SELECT_CODE, READ_CMD);
      if (er) begin
         exp.push_back({FOP_ERASE, pg});
      end
      exp.push_back({FOP_PROGRAM, pg});
      if (lk) begin
         exp.push_back({FOP_LOCK, pg});
      end
      chk("op count", exp.size(), flash_model_i.opLog.size());
      for (int i = 0; i < exp.size() && i < flash_model_i.opLog.size(); i++) begin
         chk("op order", {26'h0, exp[i]}, {26'h0, flash_model_i.opLog[i]});
      end
      wr_hs(ADDRESS_LOW_SELECT, {10'h0, pg, 2'h0});
      rd_hs(16'h5A00 + 16'(pg), {26'h0, pg, 2'h1});
   endtask

   // Mid-run reset with the external clock stopped: choice must fall back to RC
   task automatic t_slow_clock;
      extRun <= 1'b0;
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      t_reset;
      repeat (300) @(posedge sys_clk);
      wr_hs(COMMAND_SELECT_CODE, READ_CMD);
      chk("slow ext clock", 32'd0, {31'h0, useExtClock});
      chk("command after reset", 32'(K_READ), 32'(cmdKind));
   endtask

   initial begin
      #400000;
      fails++;
      $display("mismatch watchdog expected finish seen timeout");
      end_sim;
   end

   initial begin
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      t_reset;
      // Power-on wait also lets the external clock be qualified
      repeat (300) @(posedge sys_clk);
      t_decode;
      t_write_read;
      t_variant(PAGE_WRITE_LOCK_CMD, 1'b0, 1'b1, 4'h3);
      flash_model_i.opDelay = 40;
      t_variant(ERASE_THEN_WRITE_CMD, 1'b1, 1'b0, 4'h4);
      flash_model_i.opDelay = 2;
      t_variant(ERASE_WRITE_LOCK_CMD, 1'b1, 1'b1, 4'h5);
      t_slow_clock;
      end_sim;
   end
endmodule
`default_nettype wire
